// *** autoneg_next_page_gig_ctrl_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module autoneg_next_page_gig_ctrl_regs
  import gig_an_regs_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  output logic      [DATA_W-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              base_t_mode_i,
  input  wire logic              pd_fault_i,
  input  wire logic              page_rx_i,
  input  wire logic              link_partner_an_able_i,
  input  wire logic              link_partner_np_able_i,
  input  wire logic              link_partner_np_valid_i,
  input  wire logic [REG_W-1:0]  link_partner_np_word_i,
  input  wire logic              link_code_word_sent_i,
  input  wire logic              link_code_word_toggle_i,
  input  wire logic              ms_fault_i,
  input  wire logic              ms_resolved_i,
  input  wire logic              ms_resolved_master_i,
  input  wire logic              local_rx_ok_i,
  input  wire logic              remote_rx_ok_i,
  input  wire logic              link_partner_gig_fdx_i,
  input  wire logic              link_partner_gig_hdx_i,
  input  wire logic              idle_error_i,
  output logic      [2:0]        test_mode_o,
  output logic                   ms_manual_o,
  output logic                   ms_force_master_o,
  output logic                   port_multi_o,
  output logic                   adv_gig_fdx_o,
  output logic                   adv_gig_hdx_o,
  output logic      [REG_W-1:0]  np_tx_word_o
);

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              np_more;
    logic              np_msg;
    logic              np_ack2;
    logic              np_toggle;
    logic [CODE_W-1:0] np_code;
    logic [REG_W-1:0]  rx_np;
    logic [REG_W-1:0]  gig_ctl;
    logic              resolution;
  } regs_state_type;

  localparam regs_state_type RST_STATE = '{
    rdata:      '0,
    np_more:    1'b0,
    np_msg:     NP_MSG_RST,
    np_ack2:    1'b0,
    np_toggle:  1'b0,
    np_code:    NP_CODE_RST,
    rx_np:      '0,
    gig_ctl:    GIG_CTL_RST,
    resolution: RESOL_RST
  };

  regs_state_type st_ff;
  regs_state_type nxt_st;

  logic              setup;
  logic              access;
  logic              mapped;
  logic              cap_exp;
  logic              cap_sts;
  logic              rd_exp;
  logic              rd_sts;
  logic              wr_np;
  logic              wr_ctl;
  logic              pd_fault_shown;
  logic              page_rx_shown;
  logic              ms_fault_shown;
  logic [IDLE_W-1:0] idle_count;
  logic [REG_W-1:0]  exp_word;
  logic [REG_W-1:0]  np_word;
  logic [REG_W-1:0]  sts_word;
  logic [2:0]        tm_field;

  assign setup  = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign mapped = reg_hit(paddr_i, EXP_IDX) || reg_hit(paddr_i, NP_TX_IDX) ||
                  reg_hit(paddr_i, NP_RX_IDX) || reg_hit(paddr_i, GIG_CTL_IDX) ||
                  reg_hit(paddr_i, GIG_STS_IDX);

  // Read data is captured in the setup cycle; side effects of a read happen
  // at the edge that completes the access.
  assign cap_exp = setup && !pwrite_i && reg_hit(paddr_i, EXP_IDX);
  assign cap_sts = setup && !pwrite_i && reg_hit(paddr_i, GIG_STS_IDX);
  assign rd_exp  = access && !pwrite_i && reg_hit(paddr_i, EXP_IDX);
  assign rd_sts  = access && !pwrite_i && reg_hit(paddr_i, GIG_STS_IDX);
  assign wr_np   = access && pwrite_i && reg_hit(paddr_i, NP_TX_IDX);
  assign wr_ctl  = access && pwrite_i && reg_hit(paddr_i, GIG_CTL_IDX);

  status_latch #(
    .ACTIVE_LVL (1'b1)
  ) u_pd_fault (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .live_i  (pd_fault_i),
    .cap_i   (cap_exp),
    .rd_i    (rd_exp),
    .shown_o (pd_fault_shown)
  );

  status_latch #(
    .ACTIVE_LVL (1'b0)
  ) u_page_rx (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .live_i  (page_rx_i),
    .cap_i   (cap_exp),
    .rd_i    (rd_exp),
    .shown_o (page_rx_shown)
  );

  status_latch #(
    .ACTIVE_LVL (1'b1)
  ) u_ms_fault (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .live_i  (ms_fault_i),
    .cap_i   (cap_sts),
    .rd_i    (rd_sts),
    .shown_o (ms_fault_shown)
  );

  idle_err_counter #(
    .W (IDLE_W)
  ) u_idle_cnt (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .inc_i   (idle_error_i),
    .cap_i   (cap_sts),
    .rd_i    (rd_sts),
    .count_o (idle_count)
  );

  always_comb begin
    exp_word = '0;
    exp_word[EXP_PD_FAULT] = pd_fault_shown;
    exp_word[EXP_PEER_NP] = link_partner_np_able_i;
    exp_word[EXP_LOCAL_NP] = LOCAL_NP_ABLE;
    exp_word[EXP_PAGE_RX] = page_rx_shown;
    exp_word[EXP_PEER_AN] = link_partner_an_able_i;
  end

  always_comb begin
    np_word = '0;
    np_word[NP_MORE_BIT] = st_ff.np_more;
    np_word[NP_MSG_BIT] = st_ff.np_msg;
    np_word[NP_ACK2_BIT] = st_ff.np_ack2;
    np_word[NP_TOGGLE_BIT] = st_ff.np_toggle;
    np_word[CODE_W-1:0] = st_ff.np_code;
  end

  assign sts_word = {ms_fault_shown, st_ff.resolution, local_rx_ok_i, remote_rx_ok_i,
                     link_partner_gig_fdx_i, link_partner_gig_hdx_i, STS_RSVD, idle_count};

  always_comb begin
    nxt_st = st_ff;
    if (setup && !pwrite_i) begin
      nxt_st.rdata = '0;
      if (reg_hit(paddr_i, EXP_IDX)) begin
        nxt_st.rdata[REG_W-1:0] = exp_word;
      end
      if (reg_hit(paddr_i, NP_TX_IDX)) begin
        nxt_st.rdata[REG_W-1:0] = np_word;
      end
      if (reg_hit(paddr_i, NP_RX_IDX)) begin
        nxt_st.rdata[REG_W-1:0] = st_ff.rx_np;
      end
      if (reg_hit(paddr_i, GIG_CTL_IDX)) begin
        nxt_st.rdata[REG_W-1:0] = st_ff.gig_ctl;
      end
      if (reg_hit(paddr_i, GIG_STS_IDX)) begin
        nxt_st.rdata[REG_W-1:0] = sts_word;
      end
    end
    if (wr_np) begin
      nxt_st.np_more = pwdata_i[NP_MORE_BIT];
      nxt_st.np_msg  = pwdata_i[NP_MSG_BIT];
      nxt_st.np_ack2 = pwdata_i[NP_ACK2_BIT];
      nxt_st.np_code = pwdata_i[CODE_W-1:0];
    end
    if (link_code_word_sent_i) begin
      nxt_st.np_toggle = !link_code_word_toggle_i;
    end
    if (link_partner_np_valid_i) begin
      nxt_st.rx_np = link_partner_np_word_i;
    end
    if (wr_ctl) begin
      nxt_st.gig_ctl = pwdata_i[REG_W-1:0];
    end
    // Every resolution event updates the role; later timing swaps have no input here.
    if (ms_resolved_i) begin
      nxt_st.resolution = ms_resolved_master_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff <= RST_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tm_field = st_ff.gig_ctl[TM_HI_BIT:TM_LO_BIT];

  // Reserved test mode codes and non-copper media fall back to normal.
  assign test_mode_o = (base_t_mode_i && tm_legal(tm_field)) ? tm_field : TM_NORMAL;
  assign ms_manual_o = base_t_mode_i && st_ff.gig_ctl[MS_MANUAL_BIT];
  assign ms_force_master_o = ms_manual_o && st_ff.gig_ctl[MS_VALUE_BIT];
  assign port_multi_o  = st_ff.gig_ctl[PORT_BIT];
  assign adv_gig_fdx_o = st_ff.gig_ctl[ADV_FDX_BIT];
  assign adv_gig_hdx_o = st_ff.gig_ctl[ADV_HDX_BIT];
  assign np_tx_word_o  = np_word;

  assign prdata_o  = st_ff.rdata;
  assign pready_o  = access;
  assign pslverr_o = access && !mapped;

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (srst_i);

  AST_PD_FAULT_SET: assert property (
    pd_fault_i |=> pd_fault_shown ##1 (pd_fault_shown || $past(rd_exp))
  ) else $error("parallel detection fault not held");

  AST_PD_FAULT_HOLD: assert property (
    (pd_fault_shown && !rd_exp) |=> pd_fault_shown
  ) else $error("parallel detection fault dropped without read");

  AST_PAGE_RX_LOW: assert property (
    (!page_rx_i && !rd_exp) |=> !page_rx_shown
  ) else $error("page received low not held");

  AST_EXP_CONST: assert property (
    (access && !pwrite_i && reg_hit(paddr_i, EXP_IDX))
      |-> (prdata_o[REG_W-1:EXP_RSVD_LO] == '0) && prdata_o[EXP_LOCAL_NP]
  ) else $error("expansion constant bits wrong");

  AST_TOGGLE_INV: assert property (
    link_code_word_sent_i |=> np_tx_word_o[NP_TOGGLE_BIT] == !$past(link_code_word_toggle_i)
  ) else $error("toggle not inverse of last sent");

  AST_RX_NP_LOAD: assert property (
    link_partner_np_valid_i |=> st_ff.rx_np == $past(link_partner_np_word_i)
  ) else $error("partner next page not captured");

  AST_TM_LEGAL: assert property (
    (!base_t_mode_i || !tm_legal(tm_field)) |-> test_mode_o == TM_NORMAL
  ) else $error("test mode driven while illegal");

  AST_MS_GATE: assert property (
    ms_force_master_o |-> base_t_mode_i && st_ff.gig_ctl[MS_MANUAL_BIT]
  ) else $error("forced master without manual enable");

  AST_CTL_WRITE: assert property (
    wr_ctl |=> adv_gig_fdx_o == $past(pwdata_i[ADV_FDX_BIT]) &&
               adv_gig_hdx_o == $past(pwdata_i[ADV_HDX_BIT])
  ) else $error("advertise bits not written");

  AST_MS_FAULT: assert property (
    ms_fault_i |=> ms_fault_shown
  ) else $error("master slave fault not latched");

  AST_RESOL_STABLE: assert property (
    !ms_resolved_i |=> $stable(st_ff.resolution)
  ) else $error("resolution changed without resolution event");

  AST_APB_ANSWER: assert property (
    (setup && !pwrite_i) |=> (access |-> pready_o && (mapped || (prdata_o == '0)))
  ) else $error("read access not answered as expected");

  AST_NP_WRITE: assert property (
    wr_np |=> (np_tx_word_o[CODE_W-1:0] == $past(pwdata_i[CODE_W-1:0])) &&
              (np_tx_word_o[NP_MORE_BIT] == $past(pwdata_i[NP_MORE_BIT])) &&
              (np_tx_word_o[NP_MSG_BIT] == $past(pwdata_i[NP_MSG_BIT]))
  ) else $error("next page transmit fields not written");

  AST_TM_WRITE: assert property (
    (wr_ctl && base_t_mode_i) ##1 base_t_mode_i |->
      test_mode_o == (($past(pwdata_i[TM_HI_BIT:TM_LO_BIT]) <= TM_DISTORTION) ?
                      $past(pwdata_i[TM_HI_BIT:TM_LO_BIT]) : TM_NORMAL)
  ) else $error("test mode output does not follow written code");

  AST_MS_WRITE: assert property (
    (wr_ctl && base_t_mode_i) ##1 base_t_mode_i |->
      ms_force_master_o == ($past(pwdata_i[MS_MANUAL_BIT]) && $past(pwdata_i[MS_VALUE_BIT]))
  ) else $error("forced master does not follow manual value");

  AST_STS_LIVE: assert property (
    cap_sts |=> (prdata_o[REG_W-3] == $past(local_rx_ok_i)) &&
                (prdata_o[REG_W-4] == $past(remote_rx_ok_i)) &&
                (prdata_o[REG_W-5] == $past(link_partner_gig_fdx_i)) &&
                (prdata_o[REG_W-6] == $past(link_partner_gig_hdx_i))
  ) else $error("live gigabit status bits wrong in read data");

  AST_IDLE_SAT: assert property (
    (idle_count == {IDLE_W{1'b1}}) && !rd_sts |=> idle_count == {IDLE_W{1'b1}}
  ) else $error("idle error counter left saturation without read");

  AST_IDLE_CLEAR: assert property (
    (cap_sts && !idle_error_i) ##1 (rd_sts && !idle_error_i) |=> idle_count == '0
  ) else $error("idle error counter not cleared by read");

  COV_CTL_WRITE: cover property (wr_ctl ##1 test_mode_o != TM_NORMAL);
  COV_PD_READ: cover property (pd_fault_i ##1 !pd_fault_i ##[1:20] rd_exp);
  COV_IDLE_READ: cover property (idle_error_i ##[1:10] rd_sts);
  COV_UNMAPPED: cover property (pslverr_o);

endmodule

`default_nettype wire

// *** gig_an_regs_pkg.sv ***
package gig_an_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int IDLE_W = 8;
  localparam int CODE_W = 11;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] EXP_IDX     = 6'h06;
  localparam logic [5:0] NP_TX_IDX   = 6'h07;
  localparam logic [5:0] NP_RX_IDX   = 6'h08;
  localparam logic [5:0] GIG_CTL_IDX = 6'h09;
  localparam logic [5:0] GIG_STS_IDX = 6'h0a;

  // Next-page word fields, shared by the transmit and receive words.
  localparam int NP_MORE_BIT   = 15;
  localparam int NP_ACK_BIT    = 14;
  localparam int NP_MSG_BIT    = 13;
  localparam int NP_ACK2_BIT   = 12;
  localparam int NP_TOGGLE_BIT = 11;

  // Gigabit control fields.
  localparam int TM_HI_BIT     = 15;
  localparam int TM_LO_BIT     = 13;
  localparam int MS_MANUAL_BIT = 12;
  localparam int MS_VALUE_BIT  = 11;
  localparam int PORT_BIT      = 10;
  localparam int ADV_FDX_BIT   = 9;
  localparam int ADV_HDX_BIT   = 8;

  // Expansion field positions.
  localparam int EXP_RSVD_LO   = 5;
  localparam int EXP_PD_FAULT  = 4;
  localparam int EXP_PEER_NP   = 3;
  localparam int EXP_LOCAL_NP  = 2;
  localparam int EXP_PAGE_RX   = 1;
  localparam int EXP_PEER_AN   = 0;

  localparam logic [CODE_W-1:0] NP_CODE_RST   = 11'h001;
  localparam logic              NP_MSG_RST    = 1'b1;
  localparam logic [REG_W-1:0]  GIG_CTL_RST   = 16'h0700;
  localparam logic              RESOL_RST     = 1'b1;
  localparam logic              LOCAL_NP_ABLE = 1'b1;
  localparam logic [1:0]        STS_RSVD      = 2'h0;

  typedef enum logic [2:0] {
    TM_NORMAL     = 3'b000,
    TM_WAVEFORM   = 3'b001,
    TM_JIT_MASTER = 3'b010,
    TM_JIT_SLAVE  = 3'b011,
    TM_DISTORTION = 3'b100
  } test_mode_type;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  function automatic logic tm_legal(input logic [2:0] code);
    tm_legal = (code <= TM_DISTORTION);
  endfunction

endpackage

// *** idle_err_counter.sv ***
`timescale 1ns/1ps
`default_nettype none

module idle_err_counter #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         inc_i,
  input  wire logic         cap_i,
  input  wire logic         rd_i,
  output logic      [W-1:0] count_o
);

  typedef struct packed {
    logic [W-1:0] count;
    logic [W-1:0] snap;
  } cnt_state_type;

  cnt_state_type st_ff;
  cnt_state_type nxt_st;
  logic [W-1:0]  base;

  // Only the value that was handed to software is removed on a read, so
  // errors counted between capture and read survive.
  always_comb begin
    nxt_st = st_ff;
    base   = rd_i ? (st_ff.count - st_ff.snap) : st_ff.count;
    if (cap_i) begin
      nxt_st.snap = st_ff.count;
    end
    nxt_st.count = base;
    if (inc_i && (base != {W{1'b1}})) begin
      nxt_st.count = base + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count_o = st_ff.count;

endmodule

`default_nettype wire

// *** link_peer_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module link_peer_model (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        send_lcw_i,
  input  wire logic        send_np_i,
  input  wire logic [15:0] np_word_i,
  output logic             np_valid_o,
  output logic      [15:0] np_word_o,
  output logic             lcw_sent_o,
  output logic             lcw_toggle_o
);
  // The toggle flips with every sent word; the page bus churns while not valid.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      np_valid_o   <= 1'b0;
      np_word_o    <= 16'h0000;
      lcw_sent_o   <= 1'b0;
      lcw_toggle_o <= 1'b0;
    end else begin
      np_valid_o <= send_np_i;
      np_word_o  <= send_np_i ? np_word_i : ~np_word_o;
      lcw_sent_o <= send_lcw_i;
      if (send_lcw_i) begin
        lcw_toggle_o <= ~lcw_toggle_o;
      end
    end
  end
endmodule

`default_nettype wire

// *** status_latch.sv ***
`timescale 1ns/1ps
`default_nettype none

module status_latch #(
  parameter logic ACTIVE_LVL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic live_i,
  input  wire logic cap_i,
  input  wire logic rd_i,
  output logic      shown_o
);

  typedef struct packed {
    logic flag;
    logic seen;
  } latch_state_type;

  latch_state_type st_ff;
  latch_state_type nxt_st;

  // A read clears the flag only if the captured read data already showed it,
  // and a new event in the same cycle keeps it set.
  always_comb begin
    nxt_st = st_ff;
    if (cap_i) begin
      nxt_st.seen = st_ff.flag;
    end
    if (rd_i && st_ff.seen) begin
      nxt_st.flag = 1'b0;
      nxt_st.seen = 1'b0;
    end
    if (live_i == ACTIVE_LVL) begin
      nxt_st.flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign shown_o = st_ff.flag ? ACTIVE_LVL : live_i;

endmodule

`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import gig_an_regs_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e; logic err;} row_type;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        base_t = 1'b1, page_rx = 1'b0, an_able = 1'b0, np_able = 1'b0, ms_master = 1'b0;
  logic        lrx = 1'b0, rrx = 1'b0, lpf = 1'b0, lph = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic [15:0] np_in = 16'h0, np_word, np_tx;
  logic        np_valid, lcw_sent, lcw_tog, ms_man, ms_fm, pmulti, afdx, ahdx;
  logic [2:0]  test_mode;
  int          bad_count = 0, checks_done = 0, cyc = 0;
  row_type     rows[10] = '{
    '{0, 8'h18, 16'h0, 16'h0004, 0}, '{0, 8'h1c, 16'h0, 16'h2001, 0},
    '{0, 8'h20, 16'h0, 16'h0000, 0}, '{0, 8'h24, 16'h0, 16'h0700, 0},
    '{0, 8'h28, 16'h0, 16'h4000, 0}, '{1, 8'h18, 16'hffff, 16'h0004, 0},
    '{1, 8'h1c, 16'hffff, 16'hb7ff, 0}, '{1, 8'h24, 16'h1a55, 16'h1a55, 0},
    '{1, 8'h28, 16'hffff, 16'h4000, 0}, '{1, 8'h2c, 16'hffff, 16'h0000, 1}};

  autoneg_next_page_gig_ctrl_regs dut_u (
    .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .base_t_mode_i(base_t), .pd_fault_i(ev[0]), .page_rx_i(page_rx),
    .link_partner_an_able_i(an_able), .link_partner_np_able_i(np_able),
    .link_partner_np_valid_i(np_valid), .link_partner_np_word_i(np_word),
    .link_code_word_sent_i(lcw_sent), .link_code_word_toggle_i(lcw_tog),
    .ms_fault_i(ev[1]), .ms_resolved_i(ev[2]), .ms_resolved_master_i(ms_master),
    .local_rx_ok_i(lrx), .remote_rx_ok_i(rrx), .link_partner_gig_fdx_i(lpf),
    .link_partner_gig_hdx_i(lph), .idle_error_i(ev[3]), .test_mode_o(test_mode),
    .ms_manual_o(ms_man), .ms_force_master_o(ms_fm), .port_multi_o(pmulti),
    .adv_gig_fdx_o(afdx), .adv_gig_hdx_o(ahdx), .np_tx_word_o(np_tx));

  link_peer_model peer_u (
    .clk_i(clk_i), .srst_i(srst_i), .send_lcw_i(ev[4]), .send_np_i(ev[5]),
    .np_word_i(np_in), .np_valid_o(np_valid), .np_word_o(np_word),
    .lcw_sent_o(lcw_sent), .lcw_toggle_o(lcw_tog));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("Summary: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, {16'h0, e});
  endtask

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk_i);
    ev[k] <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    chk("ctl outs reset", {test_mode, ms_man, ms_fm, pmulti, afdx, ahdx}, 8'h07);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        apb(1'b1, rows[i].a, {16'h0, rows[i].d});
      end
      apb(1'b0, rows[i].a, 32'h0);
      chk("row read", rd, {16'h0, rows[i].e});
      chk("row error", {31'h0, er}, {31'h0, rows[i].err});
    end
    page_rx <= 1'b1;
    an_able <= 1'b1;
    np_able <= 1'b1;
    pulse(0);
    rchk("exp fault held", 8'h18, 16'h001d);
    rchk("exp fault cleared", 8'h18, 16'h000f);
    page_rx <= 1'b0;
    @(posedge clk_i);
    page_rx <= 1'b1;
    @(posedge clk_i);
    rchk("page low held", 8'h18, 16'h000d);
    rchk("page live", 8'h18, 16'h000f);
    for (int k = 1; k <= 2; k++) begin
      pulse(4);
      rchk("np tx toggle", 8'h1c, k[0] ? 16'hb7ff : 16'hbfff);
      chk("np tx port", {16'h0, np_tx}, {16'h0, k[0] ? 16'hb7ff : 16'hbfff});
    end
    np_in <= 16'hd8a5;
    pulse(5);
    rchk("np rx word", 8'h20, 16'hd8a5);
    // Copper mode is off for c below 8 and on from 8; every test mode code is written with manual role on and the value from c[0].
    for (int c = 0; c < 16; c++) begin
      base_t <= c[3];
      apb(1'b1, 8'h24, {16'h0, c[2:0], 1'b1, c[0], 11'h300});
      chk("ctl outs", {test_mode, ms_man, ms_fm, pmulti, afdx, ahdx},
          {(c[3] && c[2:0] <= 3'd4) ? c[2:0] : 3'd0, c[3], c[3] & c[0], 3'b011});
    end
    apb(1'b1, 8'h24, 32'h0000_0b00);
    chk("ms manual off", {30'h0, ms_man, ms_fm}, 32'h0);
    {lrx, rrx, lpf, lph} <= 4'b1010;
    pulse(2);
    pulse(1);
    repeat (3) pulse(3);
    rchk("sts events", 8'h28, 16'ha803);
    rchk("sts cleared", 8'h28, 16'h2800);
    repeat (300) pulse(3);
    rchk("idle saturates", 8'h28, 16'h28ff);
    ms_master <= 1'b1;
    pulse(2);
    rchk("resolved master", 8'h28, 16'h6800);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rchk("ctl after reset", 8'h24, 16'h0700);
    rchk("np tx after reset", 8'h1c, 16'h2001);
    chk("np tx port after reset", {16'h0, np_tx}, 32'h0000_2001);
    end_of_test();
  end
endmodule

`default_nettype wire
